// file: callerid_serial_out.sv
// callerid_serial_out: serial word port, status outputs and combined interrupt
// assumes analog front end levels on pins and an APB master on pclk
//
// The APB register port and the address map were left to the implementer.
`default_nettype none

module callerid_serial_out #(
  parameter int BIT_CYCLES = callerid_pkg::BIT_CYCLES_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [callerid_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fsk_bit,
  input wire logic carrier,
  input wire logic tone_pair,
  input wire logic guard_steer,
  input wire logic line_trigger,
  input wire logic shift_clock,
  output logic shift_clock_drive,
  output logic shift_clock_oe,
  output logic data_out,
  output logic word_ready_n,
  output logic carrier_present_n,
  output logic raw_alert,
  output logic qualified_alert,
  output logic guard_steer_drive,
  output logic guard_steer_oe,
  output logic line_event_n,
  output logic int_drive,
  output logic int_oe
);
  import callerid_pkg::*;
  localparam logic [CNT_W-1:0] PULSE_END = CNT_W'(BIT_CYCLES / PULSE_DIV - 1);
  localparam logic [CNT_W-1:0] READY_END = CNT_W'(BIT_CYCLES / READY_DIV - 1);
  localparam logic [2:0] LAST_SHIFT = 3'(WORD_BITS - 1);

  // pin synchronisers
  pins_s pins;
  logic [$bits(pins_s)-1:0] pins_raw;
  logic [$bits(pins_s)-1:0] pins_sync;

  assign pins_raw = {fsk_bit, carrier, tone_pair, guard_steer, line_trigger, shift_clock};
  assign pins = pins_s'(pins_sync);

  input_sync #(
    .W($bits(pins_s))
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(pins_raw),
    .dout(pins_sync)
  );

  // apb slave
  ctrl_s ctrl, next_ctrl;
  logic [31:0] next_prdata;
  logic setup;
  logic access;
  logic addr_hit;
  rx_event_s ev;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign pready = 1'b1;
  assign addr_hit = (paddr == CTRL_OFS) || (paddr == STATUS_OFS) || (paddr == WORD_OFS);
  assign pslverr = access & ~addr_hit;

  always_comb begin
    next_ctrl = ctrl;
    if (access && pwrite && paddr == CTRL_OFS) begin
      next_ctrl.mode = pwdata[CTRL_MODE_POS];
      next_ctrl.demod_enable = pwdata[CTRL_DEMOD_POS];
    end
    next_prdata = prdata;
    if (setup && !pwrite) begin
      next_prdata = '0;
      case (paddr)
        CTRL_OFS: begin
          next_prdata[CTRL_MODE_POS] = ctrl.mode;
          next_prdata[CTRL_DEMOD_POS] = ctrl.demod_enable;
        end
        STATUS_OFS: begin
          next_prdata[ST_READY_POS] = word_ready_n;
          next_prdata[ST_CARRIER_POS] = carrier_present_n;
          next_prdata[ST_RAW_POS] = raw_alert;
          next_prdata[ST_QUAL_POS] = qualified_alert;
          next_prdata[ST_LINE_POS] = line_event_n;
          next_prdata[ST_INT_POS] = ~int_oe;
          next_prdata[ST_MODE_POS] = ctrl.mode;
        end
        WORD_OFS: begin
          next_prdata[WORD_BITS-1:0] = ev.word;
        end
        default: begin
          next_prdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= ctrl_s'(CTRL_RESET);
      prdata <= '0;
    end else begin
      ctrl <= next_ctrl;
      prdata <= next_prdata;
    end
  end

  // status outputs
  logic next_carrier_n;
  logic next_raw;
  logic next_qual;
  logic next_line_n;

  always_comb begin
    next_carrier_n = ~pins.carrier;
    next_raw = pins.tone_pair;
    // the guard node is charged from raw_alert through the external rc
    next_qual = pins.guard_high;
    next_line_n = ~pins.trig;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carrier_present_n <= N_INACTIVE;
      raw_alert <= P_INACTIVE;
      qualified_alert <= P_INACTIVE;
      line_event_n <= N_INACTIVE;
    end else begin
      carrier_present_n <= next_carrier_n;
      raw_alert <= next_raw;
      qualified_alert <= next_qual;
      line_event_n <= next_line_n;
    end
  end

  assign guard_steer_drive = raw_alert;
  assign guard_steer_oe = 1'b1;
  // open drain: only ever pulls low
  assign int_drive = 1'b0;
  assign int_oe = ~line_event_n | ~word_ready_n | qualified_alert;

  // framing of the demodulated stream
  fsk_framer #(
    .BIT_CYCLES(BIT_CYCLES)
  ) u_framer (
    .pclk(pclk),
    .presetn(presetn),
    .rx(pins.fsk),
    .enable(ctrl.demod_enable),
    .ev(ev)
  );

  // serial port
  ser_state_e ser, next_ser;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic last, next_last;
  logic [WORD_BITS-1:0] hold, next_hold;
  logic [2:0] shift_idx, next_shift_idx;
  logic sclk_prev;
  logic mode_prev;
  logic sclk_rise;
  logic hold_lsb;
  logic next_sclk_o;
  logic next_ready_n;
  logic next_data;

  assign sclk_rise = pins.shift_clk & ~sclk_prev;
  assign hold_lsb = hold[0];
  assign shift_clock_oe = ~ctrl.mode;

  always_comb begin
    next_ser = ser;
    next_cnt = cnt;
    next_last = last;
    next_hold = hold;
    next_shift_idx = shift_idx;
    next_sclk_o = shift_clock_drive;
    next_ready_n = word_ready_n;
    next_data = data_out;
    if (ctrl.mode != mode_prev) begin
      // a mode change abandons any word in progress
      next_ser = SER_IDLE;
      next_cnt = '0;
      next_sclk_o = 1'b0;
      next_ready_n = N_INACTIVE;
    end else if (!ctrl.mode) begin
      next_data = pins.fsk | ~ctrl.demod_enable;
      case (ser)
        SER_IDLE: begin
          if (ev.bit_strobe) begin
            next_ser = SER_PULSE;
            next_sclk_o = 1'b1;
            next_cnt = '0;
            next_last = ev.word_done;
          end
        end
        SER_PULSE: begin
          next_cnt = cnt + 1'b1;
          if (cnt == PULSE_END) begin
            next_sclk_o = 1'b0;
            next_cnt = '0;
            next_ser = last ? SER_READY : SER_IDLE;
            next_ready_n = ~last;
          end
        end
        SER_READY: begin
          next_cnt = cnt + 1'b1;
          if (cnt == READY_END) begin
            next_ser = SER_IDLE;
            next_ready_n = N_INACTIVE;
          end
        end
        default: begin
          next_ser = SER_IDLE;
        end
      endcase
    end else begin
      if (ev.word_valid) begin
        // a new word replaces one that was not fully fetched
        next_hold = ev.word;
        next_shift_idx = '0;
        next_ser = SER_HOLD;
        next_ready_n = 1'b0;
      end else if (ser == SER_HOLD && sclk_rise) begin
        next_data = hold[0];
        next_hold = {1'b0, hold[WORD_BITS-1:1]};
        next_shift_idx = shift_idx + 1'b1;
        if (shift_idx == LAST_SHIFT) begin
          next_ready_n = N_INACTIVE;
          next_ser = SER_IDLE;
        end
      end else if (ser != SER_HOLD) begin
        next_ser = SER_IDLE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser <= SER_IDLE;
      cnt <= '0;
      last <= 1'b0;
      hold <= '0;
      shift_idx <= '0;
      sclk_prev <= 1'b0;
      mode_prev <= 1'b0;
      shift_clock_drive <= 1'b0;
      word_ready_n <= N_INACTIVE;
      data_out <= N_INACTIVE;
    end else begin
      ser <= next_ser;
      cnt <= next_cnt;
      last <= next_last;
      hold <= next_hold;
      shift_idx <= next_shift_idx;
      sclk_prev <= pins.shift_clk;
      mode_prev <= ctrl.mode;
      shift_clock_drive <= next_sclk_o;
      word_ready_n <= next_ready_n;
      data_out <= next_data;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence word_loaded;
    ctrl.mode && mode_prev && ev.word_valid;
  endsequence

  sequence last_bit_out;
    ctrl.mode && mode_prev && ser == SER_HOLD && sclk_rise && !ev.word_valid
      && shift_idx == LAST_SHIFT;
  endsequence

  a_ready_after_clk: assert property ($fell(word_ready_n) && !ctrl.mode
      |-> $fell(shift_clock_drive))
    else $error("mode 0 word ready did not follow the last shift clock");

  a_ready_on_word: assert property (word_loaded |=> !word_ready_n)
    else $error("mode 1 word ready not asserted for a new word");

  a_carrier_follow: assert property (carrier [*6] |-> !carrier_present_n)
    else $error("carrier present not reported");

  a_int_sources: assert property ((!line_event_n || !word_ready_n || qualified_alert)
      |-> int_oe && !int_drive)
    else $error("interrupt not driven for an active source");

  // release must coincide with the last source going inactive, never a glitch
  a_int_release: assert property ($fell(int_oe)
      |-> line_event_n && word_ready_n && !qualified_alert
      && ($rose(line_event_n) || $rose(word_ready_n) || $fell(qualified_alert)))
    else $error("interrupt released while a source is active");

  a_qual_rise: assert property (guard_steer [*6] |-> qualified_alert)
    else $error("qualified alert missing with guard node high");

  a_qual_fall: assert property ((!guard_steer) [*6] |-> !qualified_alert)
    else $error("qualified alert held with guard node low");

  a_qual_cause: assert property ($rose(qualified_alert) |-> $past(guard_steer, 3))
    else $error("qualified alert rose without the guard node");

  a_raw_drive: assert property (tone_pair [*6] |-> raw_alert && guard_steer_drive)
    else $error("raw alert not reported or not driven to guard node");

  a_pulse_width: assert property ($rose(shift_clock_drive) && !ctrl.mode
      |-> shift_clock_drive [*8])
    else $error("mode 0 shift clock pulse too short");

  a_clk_release: assert property ($rose(ctrl.mode)
      |=> !shift_clock_drive && !shift_clock_oe)
    else $error("shift clock still driven in mode 1");

  a_shift_on_rise: assert property (ctrl.mode && mode_prev && ser == SER_HOLD && sclk_rise
      && !ev.word_valid |=> data_out == $past(hold_lsb))
    else $error("mode 1 bit not shifted on the rising edge");

  a_ready_release: assert property (last_bit_out |=> word_ready_n)
    else $error("word ready not released after eight bits");
endmodule // callerid_serial_out

`default_nettype wire

// file: callerid_pkg.sv
// callerid_pkg: constants, register map and types of the caller-id serial output block
// assumes a 25 MHz pclk, an APB master, and analog front-end levels arriving on pins
`default_nettype none

package callerid_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD = 1200;
  localparam int BIT_CYCLES_DEFAULT = CLK_HZ / BAUD;
  localparam int WORD_BITS = 8;
  localparam int CNT_W = 16;
  localparam int PULSE_DIV = 4;
  localparam int READY_DIV = 2;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] WORD_OFS = 8'h08;
  localparam int CTRL_MODE_POS = 0;
  localparam int CTRL_DEMOD_POS = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int ST_READY_POS = 0;
  localparam int ST_CARRIER_POS = 1;
  localparam int ST_RAW_POS = 2;
  localparam int ST_QUAL_POS = 3;
  localparam int ST_LINE_POS = 4;
  localparam int ST_INT_POS = 5;
  localparam int ST_MODE_POS = 6;
  localparam logic N_INACTIVE = 1'h1;
  localparam logic P_INACTIVE = 1'h0;

  typedef enum logic [1:0] {
    RX_IDLE = 2'h0,
    RX_START = 2'h1,
    RX_DATA = 2'h3,
    RX_STOP = 2'h2
  } rx_state_e;

  typedef enum logic [1:0] {
    SER_IDLE = 2'h0,
    SER_PULSE = 2'h1,
    SER_READY = 2'h3,
    SER_HOLD = 2'h2
  } ser_state_e;

  typedef struct packed {
    logic demod_enable;
    logic mode;
  } ctrl_s;

  typedef struct packed {
    logic fsk;
    logic carrier;
    logic tone_pair;
    logic guard_high;
    logic trig;
    logic shift_clk;
  } pins_s;

  typedef struct packed {
    logic bit_strobe;
    logic bit_value;
    logic word_done;
    logic word_valid;
    logic [WORD_BITS-1:0] word;
  } rx_event_s;
endpackage

`default_nettype wire

// file: input_sync.sv
// input_sync: three-stage synchroniser with agreement filter, one per bit
// assumes inputs are asynchronous to pclk; output changes once stages two and three agree
`default_nettype none

module input_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic [2:0] ff;
      logic level;
      logic next_out;
      always_comb begin
        next_out = (ff[1] == ff[2]) ? ff[1] : level;
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ff <= 3'h0;
          level <= 1'h0;
        end else begin
          ff <= {ff[1], ff[0], din[i]};
          level <= next_out;
        end
      end
      assign dout[i] = level;
    end
  endgenerate
endmodule // input_sync

`default_nettype wire

// file: fsk_framer.sv
// fsk_framer: recovers start, eight data bits lsb first and stop from the demodulated stream
// assumes rx is already synchronised to pclk and idles high
`default_nettype none

module fsk_framer #(
  parameter int BIT_CYCLES = callerid_pkg::BIT_CYCLES_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rx,
  input wire logic enable,
  output var callerid_pkg::rx_event_s ev
);
  import callerid_pkg::*;
  localparam logic [CNT_W-1:0] FULL_END = CNT_W'(BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] HALF_END = CNT_W'(BIT_CYCLES / 2 - 1);
  localparam logic [2:0] LAST_IDX = 3'(WORD_BITS - 1);

  rx_state_e state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [2:0] idx, next_idx;
  logic [WORD_BITS-1:0] shreg, next_shreg;
  logic rx_prev;
  rx_event_s next_ev;

  always_comb begin
    next_state = state;
    next_cnt = cnt + 1'b1;
    next_idx = idx;
    next_shreg = shreg;
    next_ev = '0;
    next_ev.word = ev.word;
    next_ev.bit_value = ev.bit_value;
    case (state)
      RX_IDLE: begin
        next_cnt = '0;
        if (rx_prev && !rx) begin
          next_state = RX_START;
        end
      end
      RX_START: begin
        if (cnt == HALF_END) begin
          next_cnt = '0;
          next_idx = '0;
          next_state = rx ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (cnt == FULL_END) begin
          // mid-bit sample of each data bit
          next_cnt = '0;
          next_ev.bit_strobe = 1'b1;
          next_ev.bit_value = rx;
          next_shreg = {rx, shreg[WORD_BITS-1:1]};
          next_idx = idx + 1'b1;
          if (idx == LAST_IDX) begin
            next_ev.word_done = 1'b1;
            next_state = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (cnt == FULL_END) begin
          // a word without a valid stop bit is dropped
          next_ev.word_valid = rx;
          if (rx) begin
            next_ev.word = shreg;
          end
          next_state = RX_IDLE;
        end
      end
      default: next_state = RX_IDLE;
    endcase
    if (!enable) begin
      next_state = RX_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= RX_IDLE;
      cnt <= '0;
      idx <= '0;
      shreg <= '0;
      rx_prev <= N_INACTIVE;
      ev <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      idx <= next_idx;
      shreg <= next_shreg;
      rx_prev <= rx;
      ev <= next_ev;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_stop_good: assert property (ev.word_valid |-> $past(rx) && $past(state) == RX_STOP)
    else $error("word accepted without a stop bit");
endmodule // fsk_framer

`default_nettype wire

// file: host_mcu.sv
// host_mcu: model of the host on the far side of the three-wire serial port
// assumes the bench resolves the shift clock pin and hands its level back on shift_pin
`default_nettype none

module host_mcu (
  input wire logic pclk,
  input wire logic shift_clock_oe,
  input wire logic shift_pin,
  input wire logic data_out,
  output logic host_clk,
  output logic [7:0] cap,
  output logic [7:0] pulses
);
  timeunit 1ns;
  timeprecision 1ps;
  logic shift_seen;

  initial begin
    host_clk = 1'b0;
    cap = 8'h00;
    pulses = 8'h00;
    shift_seen = 1'b0;
  end

  // device-clocked words: take data_out at each device shift clock rise, lsb first
  always @(posedge pclk) begin
    shift_seen <= shift_pin;
    if (shift_clock_oe && shift_pin && !shift_seen) begin
      cap <= {data_out, cap[7:1]};
      pulses <= pulses + 8'h01;
    end
  end

  // host-clocked fetch at 320 ns per bit; the clock rests low between words
  task automatic fetch(output logic [7:0] b);
    #7;
    for (int i = 0; i < 8; i++) begin
      host_clk = 1'b1;
      #160;
      host_clk = 1'b0;
      #140;
      b[i] = data_out;
      #20;
    end
  endtask
endmodule // host_mcu

`default_nettype wire

// file: testbench.sv
// testbench: self-checking bench of callerid_serial_out with an apb master and a host model
// assumes callerid_pkg and host_mcu are compiled first; BIT_CYCLES shortened to 64
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import callerid_pkg::*;
  localparam int BITC = 64;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic fsk_bit_in, carrier_in, tone_pair_in, guard_steer_in, trig_in;
  logic shift_clock_o, shift_clock_oe, data_out, word_ready_n, carrier_present_n;
  logic raw_alert, qualified_alert, guard_steer_o, guard_steer_oe, line_event_n;
  logic int_o, int_oe, host_clk, shift_pin, int_n, err, mode;
  logic [7:0] cap, pulses, p0, b, got;
  int fail_count, num_checks;
  logic [7:0] sent_q[$];

  assign shift_pin = shift_clock_oe ? shift_clock_o : host_clk;
  // open-drain interrupt wire with a pull-up
  assign int_n = int_oe ? int_o : 1'b1;

  callerid_serial_out #(.BIT_CYCLES(BITC)) i_callerid_serial_out (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .fsk_bit(fsk_bit_in), .carrier(carrier_in), .tone_pair(tone_pair_in),
    .guard_steer(guard_steer_in), .line_trigger(trig_in), .shift_clock(shift_pin),
    .shift_clock_drive(shift_clock_o), .shift_clock_oe, .data_out, .word_ready_n,
    .carrier_present_n, .raw_alert, .qualified_alert, .guard_steer_drive(guard_steer_o),
    .guard_steer_oe, .line_event_n, .int_drive(int_o), .int_oe
  );

  host_mcu host (.pclk, .shift_clock_oe, .shift_pin, .data_out, .host_clk, .cap, .pulses);

  always #20 pclk = ~pclk;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic expire();
    fail_count++;
    results();
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) expire();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] exp_status(input logic wr_n);
    logic irq;
    irq = trig_in | !wr_n | guard_steer_in;
    return {25'h0, mode, !irq, !trig_in, guard_steer_in, tone_pair_in, !carrier_in, wr_n};
  endfunction

  task automatic check_status();
    check("carrier_n", {31'h0, carrier_present_n}, {31'h0, !carrier_in});
    check("raw_alert", {31'h0, raw_alert}, {31'h0, tone_pair_in});
    check("guard_drive", {31'h0, guard_steer_o}, {31'h0, tone_pair_in});
    check("qual_alert", {31'h0, qualified_alert}, {31'h0, guard_steer_in});
    check("line_n", {31'h0, line_event_n}, {31'h0, !trig_in});
    check("int_n", {31'h0, int_n}, {31'h0, !(trig_in | guard_steer_in)});
    apb(1'b0, STATUS_OFS, 32'h0);
    check("status", rd, exp_status(1'b1));
  endtask

  task automatic send(input logic [7:0] v);
    logic [9:0] fr;
    fr = {1'b1, v, 1'b0};
    sent_q.push_back(v);
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      fsk_bit_in <= fr[i];
      repeat (BITC - 1) @(posedge pclk);
    end
    repeat (BITC) @(posedge pclk);
  endtask

  task automatic wait_low(input logic [7:0] start);
    int n;
    n = 0;
    while (word_ready_n !== 1'b0 && n < 12 * BITC) begin
      @(posedge pclk);
      n++;
    end
    if (word_ready_n !== 1'b0) expire();
    check("pulses", {24'h0, pulses}, {24'h0, start + 8'h08});
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fsk_bit_in = 1'b1;
    carrier_in = 1'b0;
    tone_pair_in = 1'b0;
    guard_steer_in = 1'b0;
    trig_in = 1'b0;
    mode = 1'b0;
    fail_count = 0;
    num_checks = 0;
    void'($urandom(32'hc7a21631));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    check_status();
    apb(1'b0, CTRL_OFS, 32'h0);
    check("ctrl_rst", rd, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    check("unmapped", {rd[30:0], err}, 32'h1);
    apb(1'b1, STATUS_OFS, 32'hffffffff);
    check_status();
    for (int k = 0; k < 8; k++) begin
      b = (k == 7) ? 8'h00 : 8'($urandom());
      @(posedge pclk);
      carrier_in <= b[0];
      tone_pair_in <= b[1];
      guard_steer_in <= b[2];
      trig_in <= b[3];
      repeat (8) @(posedge pclk);
      check_status();
    end
    // demodulator off: a full frame must give no pulses and no word
    p0 = pulses;
    send(8'h5a);
    void'(sent_q.pop_front());
    check("off_pulses", {24'h0, pulses}, {24'h0, p0});
    check("off_ready", {31'h0, word_ready_n}, 32'h1);
    for (int m = 0; m < 2; m++) begin
      mode = m[0];
      apb(1'b1, CTRL_OFS, {30'h0, 1'b1, mode});
      repeat (2) @(posedge pclk);
      check("clk_oe", {31'h0, shift_clock_oe}, {31'h0, !mode});
      for (int j = 0; j < 2; j++) begin
        b = 8'($urandom());
        p0 = pulses;
        if (!mode) begin
          fork
            send(b);
            wait_low(p0);
          join
          check("word_m0", {24'h0, cap}, {24'h0, sent_q.pop_front()});
        end else begin
          send(b);
          check("ready_m1", {31'h0, word_ready_n}, 32'h0);
          check("int_m1", {31'h0, int_n}, 32'h0);
          host.fetch(got);
          repeat (4) @(posedge pclk);
          check("word_m1", {24'h0, got}, {24'h0, sent_q.pop_front()});
          check("done_m1", {31'h0, word_ready_n}, 32'h1);
          check("int_rel", {31'h0, int_n}, 32'h1);
        end
        apb(1'b0, WORD_OFS, 32'h0);
        check("word_reg", rd, {24'h0, b});
      end
    end
    results();
  end
endmodule // testbench

`default_nettype wire
